// ---- design/flmfc_pkg.sv ----
`default_nettype none
package flmfc_pkg;
	// ****************************************************
	// Sizes and link defaults
	// ****************************************************
	localparam int DATA_W_DEF = 8;
	localparam int DEPTH_DEF = 16;
	localparam int ADDR_W_DEF = 4;
	// Pointer snapshot delay that models the clock crossing
	localparam int XING_STAGES = 2;
	// Default thresholds used as build constants and reset values
	localparam int THR_ASSERT_DEF = 4;
	localparam int THR_NEGATE_DEF = 7;
	// Flag shows an empty FIFO while reset is held
	localparam logic LOW_MARK_RST = 1'b1;

	// ****************************************************
	// Register map of the user end (Avalon-MM byte addresses)
	// ****************************************************
	localparam logic [7:0] OFF_WDATA = 8'h00;
	localparam logic [7:0] OFF_RDATA = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_THRESH = 8'h0C;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	// Field positions
	localparam int STAT_FULL = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_LOW = 2;
	localparam int STAT_CNT_LSB = 8;
	localparam int STAT_RDCNT_LSB = 16;
	localparam int THR_ASSERT_LSB = 0;
	localparam int THR_NEGATE_LSB = 16;
	localparam int CTRL_HOLD = 0;
	// Reset values
	localparam logic CTRL_HOLD_RST = 1'b0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ****************************************************
	// User end bus sequencer
	// ****************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_POP = 2'b01,
		ST_ANS = 2'b10
	} flmfc_state_t;
endpackage
`default_nettype wire

// ---- design/flmfc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Link between the FIFO status device and the user logic
interface flmfc_if #(
	parameter int DATA_W = 8,
	parameter int AW = 4
) ();
	// Write port
	logic wr_en;
	logic [DATA_W-1:0] wr_data;
	logic full;
	// Read port
	logic rd_en;
	logic [DATA_W-1:0] rd_data;
	logic rd_valid;
	logic empty;
	// Thresholds, status and reset hold
	logic [AW-1:0] thr_assert;
	logic [AW-1:0] thr_negate;
	logic low_mark;
	logic [AW-1:0] data_count;
	logic [AW-1:0] rd_count;
	logic hold_rst;

	modport dev (
		input wr_en, wr_data, rd_en, thr_assert, thr_negate, hold_rst,
		output full, rd_data, rd_valid, empty, low_mark, data_count,
		output rd_count
	);
	modport usr (
		output wr_en, wr_data, rd_en, thr_assert, thr_negate, hold_rst,
		input full, rd_data, rd_valid, empty, low_mark, data_count,
		input rd_count
	);
endinterface
`default_nettype wire

// ---- design/flmfc_low_mark.sv ----
`timescale 1ns/1ps
`default_nettype none
// Low-level flag with single or assert/negate thresholds
module flmfc_low_mark #(
	parameter int AW = 4,
	parameter bit BUILTIN = 1'b0,
	parameter bit HYST = 1'b0
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Level and thresholds
	input wire logic [AW-1:0] level_in,
	input wire logic [AW-1:0] thr_assert_in,
	input wire logic [AW-1:0] thr_negate_in,
	// Flag
	output logic low_mark_out
);
	import flmfc_pkg::*;

	logic [AW:0] neg_lim;

	// Clear point: negate value, threshold, or threshold+1 on hard FIFOs
	always_comb begin
		if (HYST) begin
			neg_lim = {1'b0, thr_negate_in};
		end else if (BUILTIN) begin
			neg_lim = {1'b0, thr_assert_in} + {{AW{1'b0}}, 1'b1};
		end else begin
			neg_lim = {1'b0, thr_assert_in};
		end
	end

	// Registered, so the flag trails the level by one edge
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			low_mark_out <= LOW_MARK_RST;
		end else if (level_in <= thr_assert_in) begin
			low_mark_out <= 1'b1;
		end else if ({1'b0, level_in} > neg_lim) begin
			low_mark_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- design/flmfc_dev.sv ----
// What this block does
// - Flag set when entries at/below assert threshold
// - Flag cleared when entries exceed negate threshold, in hysteresis mode only
// - Read reaching threshold raises flag next edge
// - Hard FIFO single mode clears above threshold+1
// - Soft FIFO single mode clears above threshold
// - Single threshold port changes only during reset
// - Assert/negate ports change only during reset
// - Hysteresis: set at assert, clear above negate
// - Hysteresis only for soft implementations
// - Assert value strictly below negate value
// - Flag and read count lag one cycle
// - Hard FIFO thresholds kept within one primitive
// - Count width up to log2 depth, upper kept
// - Common-clock count exact, same edge update
// - Read count lags a pop by one edge, so it over-reports by one then
// - Read count width selectable, upper bits kept
// - Read shows next edge; writes show later
// - Counts only for RAM and shift-register types
// - Each count port always exists; a disabled one reads as zero
`timescale 1ns/1ps
`default_nettype none
module flmfc_dev #(
	parameter int DATA_W = flmfc_pkg::DATA_W_DEF,
	parameter int DEPTH = flmfc_pkg::DEPTH_DEF,
	parameter bit BUILTIN = 1'b0,
	parameter bit HYST = 1'b0,
	parameter bit THRESH_PORT = 1'b1,
	parameter int THR_ASSERT = flmfc_pkg::THR_ASSERT_DEF,
	parameter int THR_NEGATE = flmfc_pkg::THR_NEGATE_DEF,
	parameter bit INDEP = 1'b0,
	parameter bit COUNT_EN = 1'b1,
	parameter int COUNT_W = flmfc_pkg::ADDR_W_DEF,
	parameter bit RD_COUNT_EN = 1'b1,
	parameter int RD_COUNT_W = flmfc_pkg::ADDR_W_DEF
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Link to the user logic
	flmfc_if.dev link
);
	import flmfc_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ****************************************************
	// Build-time checks
	// ****************************************************
	if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two of at least 4");
	end
	if ($bits(link.wr_data) != DATA_W || $bits(link.rd_count) != AW)
	begin : g_bad_link
		$error("link widths do not match DATA_W and DEPTH");
	end
	if (BUILTIN && (HYST || THRESH_PORT)) begin : g_bad_builtin
		$error("hard FIFO has only a constant single threshold");
	end
	if (BUILTIN && (COUNT_EN || RD_COUNT_EN)) begin : g_bad_count
		$error("hard FIFO offers no fill counts");
	end
	if (INDEP && COUNT_EN) begin : g_bad_indep
		$error("exact count exists only with a common clock");
	end
	if (COUNT_W < 1 || COUNT_W > AW || RD_COUNT_W < 1 || RD_COUNT_W > AW)
	begin : g_bad_w
		$error("count width must lie between 1 and log2 of depth");
	end
	if (HYST && !THRESH_PORT && THR_ASSERT >= THR_NEGATE)
	begin : g_bad_thr
		$error("assert threshold must be below negate threshold");
	end
	if (THR_ASSERT < 0 || THR_ASSERT >= DEPTH || THR_NEGATE < 0 ||
		THR_NEGATE >= DEPTH) begin : g_bad_range
		$error("threshold constants out of range");
	end

	// Upper bits of a level, moved down to bit 0
	function automatic logic [AW-1:0] keep_upper(
		input logic [AW-1:0] v,
		input int unsigned w
	);
		keep_upper = v >> (AW - w);
	endfunction

	// ****************************************************
	// Storage and pointers
	// ****************************************************
	logic rst_n;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW-1:0] count_ff;
	logic [AW-1:0] wp_snap_ff [XING_STAGES];
	logic [AW-1:0] rd_lvl;
	logic [AW-1:0] flag_lvl;
	logic [AW-1:0] th_a;
	logic [AW-1:0] th_n;
	logic [DATA_W-1:0] rd_data_ff;
	logic rd_valid_ff;
	logic [AW-1:0] rd_count_ff;
	logic wr_ok;
	logic rd_ok;

	// Holding the link reset lets the user end change thresholds safely
	assign rst_n = resetn_in & ~link.hold_rst;

	// One slot stays free so the level fits in log2(depth) bits
	assign link.full = (count_ff == AW'(DEPTH - 1));
	// Empty follows the read view so a read never underflows
	assign link.empty = (rd_lvl == '0);
	assign wr_ok = link.wr_en & ~link.full;
	assign rd_ok = link.rd_en & ~link.empty;

	// Array write; no reset on the storage itself
	always_ff @(posedge clock_in) begin
		if (wr_ok) begin
			mem[wp_ff] <= link.wr_data;
		end
	end

	// Write pointer
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
		end else if (wr_ok) begin
			wp_ff <= wp_ff + AW'(1);
		end
	end

	// Read pointer and read data
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rp_ff <= '0;
			rd_data_ff <= '0;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= rd_ok;
			if (rd_ok) begin
				rp_ff <= rp_ff + AW'(1);
				rd_data_ff <= mem[rp_ff];
			end
		end
	end

	// ****************************************************
	// Fill levels
	// ****************************************************
	// Exact level, moves at the very edge of the write or read
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= '0;
		end else begin
			case ({wr_ok, rd_ok})
				2'b10: count_ff <= count_ff + AW'(1);
				2'b01: count_ff <= count_ff - AW'(1);
				default: count_ff <= count_ff;
			endcase
		end
	end

	// Write pointer seen late by the read side, as across a crossing
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < XING_STAGES; i++) begin
				wp_snap_ff[i] <= '0;
			end
		end else begin
			wp_snap_ff[0] <= wp_ff;
			for (int i = 1; i < XING_STAGES; i++) begin
				wp_snap_ff[i] <= wp_snap_ff[i-1];
			end
		end
	end

	// Stale write pointer against live read pointer: only under-reports
	always_comb begin
		if (INDEP) begin
			rd_lvl = wp_snap_ff[XING_STAGES-1] - rp_ff;
		end else begin
			rd_lvl = count_ff;
		end
	end

	// Read count trails its level by one edge
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_count_ff <= '0;
		end else begin
			rd_count_ff <= rd_lvl;
		end
	end

	// ****************************************************
	// Low-level flag
	// ****************************************************
	assign th_a = THRESH_PORT ? link.thr_assert : AW'(THR_ASSERT);
	assign th_n = THRESH_PORT ? link.thr_negate : AW'(THR_NEGATE);
	assign flag_lvl = INDEP ? rd_lvl : count_ff;

	flmfc_low_mark #(
		.AW(AW),
		.BUILTIN(BUILTIN),
		.HYST(HYST)
	) u_low_mark (
		.clock_in(clock_in),
		.resetn_in(rst_n),
		.level_in(flag_lvl),
		.thr_assert_in(th_a),
		.thr_negate_in(th_n),
		.low_mark_out(link.low_mark)
	);

	// ****************************************************
	// Outputs
	// ****************************************************
	assign link.rd_data = rd_data_ff;
	assign link.rd_valid = rd_valid_ff;
	// A disabled count reads as zero in place of a missing port
	assign link.data_count = COUNT_EN ?
		keep_upper(count_ff, COUNT_W) : '0;
	assign link.rd_count = RD_COUNT_EN ?
		keep_upper(rd_count_ff, RD_COUNT_W) : '0;
endmodule
`default_nettype wire

// ---- design/flmfc_user.sv ----
`timescale 1ns/1ps
`default_nettype none
// User logic: drives the FIFO link from Avalon-MM registers
module flmfc_user #(
	parameter int DATA_W = flmfc_pkg::DATA_W_DEF,
	parameter int AW = flmfc_pkg::ADDR_W_DEF,
	parameter bit HYST = 1'b0
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Link to the FIFO
	flmfc_if.usr link
);
	import flmfc_pkg::*;

	if (DATA_W > 32 || AW > 16) begin : g_bad_w
		$error("DATA_W above 32 or AW above 16 not served");
	end

	flmfc_state_t state_ff;
	logic hold_ff;
	logic [AW-1:0] thr_a_ff;
	logic [AW-1:0] thr_n_ff;
	logic [31:0] rdata_ff;
	logic [31:0] reg_val;
	logic [AW-1:0] new_a;
	logic [AW-1:0] new_n;
	logic hit_wdata;
	logic hit_rdata;
	logic wr_take;

	assign hit_wdata = (avs_address_in == OFF_WDATA);
	assign hit_rdata = (avs_address_in == OFF_RDATA);
	assign new_a = avs_writedata_in[THR_ASSERT_LSB +: AW];
	assign new_n = avs_writedata_in[THR_NEGATE_LSB +: AW];

	// Writes land in idle only; a push stalls while the FIFO is full
	assign avs_waitrequest_out = avs_read_in ? (state_ff != ST_ANS) :
		(state_ff != ST_IDLE || (hit_wdata && link.full));
	assign wr_take = avs_write_in && !avs_waitrequest_out;

	// Push and pop strobes
	assign link.wr_en = wr_take && hit_wdata;
	assign link.wr_data = avs_writedata_in[DATA_W-1:0];
	assign link.rd_en = (state_ff == ST_IDLE) && avs_read_in &&
		hit_rdata && !link.empty;

	// Readback value of the non-popping registers
	always_comb begin
		reg_val = '0;
		case (avs_address_in)
			OFF_STATUS: begin
				reg_val[STAT_FULL] = link.full;
				reg_val[STAT_EMPTY] = link.empty;
				reg_val[STAT_LOW] = link.low_mark;
				reg_val[STAT_CNT_LSB +: AW] = link.data_count;
				reg_val[STAT_RDCNT_LSB +: AW] = link.rd_count;
			end
			OFF_THRESH: begin
				reg_val[THR_ASSERT_LSB +: AW] = thr_a_ff;
				reg_val[THR_NEGATE_LSB +: AW] = thr_n_ff;
			end
			OFF_CTRL: reg_val[CTRL_HOLD] = hold_ff;
			default: reg_val = '0;
		endcase
	end

	// Read sequencer: register reads answer one cycle after capture, pops one cycle later
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= ST_IDLE;
			rdata_ff <= RDATA_RST;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (link.rd_en) begin
						state_ff <= ST_POP;
					end else if (avs_read_in && !hit_rdata) begin
						rdata_ff <= reg_val;
						state_ff <= ST_ANS;
					end
				end
				ST_POP: begin
					if (link.rd_valid) begin
						rdata_ff <= 32'(link.rd_data);
						state_ff <= ST_ANS;
					end
				end
				ST_ANS: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Reset hold of the FIFO
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hold_ff <= CTRL_HOLD_RST;
		end else if (wr_take && avs_address_in == OFF_CTRL) begin
			hold_ff <= avs_writedata_in[CTRL_HOLD];
		end
	end

	// Thresholds move only while the FIFO is held in reset
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			thr_a_ff <= AW'(THR_ASSERT_DEF);
			thr_n_ff <= AW'(THR_NEGATE_DEF);
		end else if (wr_take && avs_address_in == OFF_THRESH &&
			hold_ff && (!HYST || new_a < new_n)) begin
			thr_a_ff <= new_a;
			thr_n_ff <= new_n;
		end
	end

	assign link.thr_assert = thr_a_ff;
	assign link.thr_negate = thr_n_ff;
	assign link.hold_rst = hold_ff;
	assign avs_readdata_out = rdata_ff;
endmodule
`default_nettype wire

// ---- testbench/flmfc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Link checker
// ****************************************************
module flmfc_chk #(
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Requests from the user end
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic hold_rst_in,
	input wire logic [AW-1:0] thr_assert_in,
	// Device status
	input wire logic full_in,
	input wire logic empty_in,
	input wire logic rd_valid_in,
	input wire logic low_mark_in,
	input wire logic [AW-1:0] data_count_in,
	input wire logic [AW-1:0] rd_count_in
);
	// A held FIFO reset empties the store, so all checks but AST_RST pause with it
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in || hold_rst_in);
	logic push;
	logic pop;
	// Transfers the device accepts
	assign push = wr_en_in && !full_in;
	assign pop = rd_en_in && !empty_in;

	AST_CNT_UP: assert property (
		push && !pop |=> data_count_in == $past(data_count_in) + 1'b1)
		else $error("count missed a push");
	AST_CNT_DN: assert property (
		pop && !push |=> data_count_in == $past(data_count_in) - 1'b1)
		else $error("count missed a pop");
	AST_CNT_IDLE: assert property (
		!push && !pop |=> $stable(data_count_in))
		else $error("count moved without a transfer");
	AST_LOW_SET: assert property (
		data_count_in <= thr_assert_in |=> low_mark_in)
		else $error("low flag not raised");
	AST_LOW_CLR: assert property (
		data_count_in > thr_assert_in |=> !low_mark_in)
		else $error("low flag not cleared");
	AST_RD_LAG: assert property (
		1'b1 |=> rd_count_in == $past(data_count_in))
		else $error("read count lag wrong");
	// Back-to-back pops keep the strobe high, so judge each edge alone
	AST_VALID: assert property (
		pop |=> rd_valid_in)
		else $error("read data strobe missing");
	AST_NO_VALID: assert property (
		!pop |=> !rd_valid_in)
		else $error("read data strobe without a pop");
	AST_RST: assert property (@(posedge clock_in)
		disable iff (!resetn_in) hold_rst_in |=>
		data_count_in == '0 && rd_count_in == '0 && low_mark_in)
		else $error("held reset does not show empty");
endmodule
`default_nettype wire

// ---- testbench/flmfc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Testbench top
// ****************************************************
module flmfc_tb_top;
	import flmfc_pkg::*;
	logic clock_in;
	logic resetn_in;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [31:0] rd_val;
	int n_mismatch;
	int n_checks;

	flmfc_if #(.DATA_W(DATA_W_DEF), .AW(ADDR_W_DEF)) lnk ();
	flmfc_dev i_flmfc_dev (.clock_in(clock_in), .resetn_in(resetn_in),
		.link(lnk.dev));
	flmfc_user i_flmfc_user (.clock_in(clock_in), .resetn_in(resetn_in),
		.avs_address_in(avs_address), .avs_read_in(avs_read),
		.avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
		.avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest), .link(lnk.usr));
	flmfc_chk #(.AW(ADDR_W_DEF)) i_flmfc_chk (.clock_in(clock_in),
		.resetn_in(resetn_in), .wr_en_in(lnk.wr_en),
		.rd_en_in(lnk.rd_en), .hold_rst_in(lnk.hold_rst),
		.thr_assert_in(lnk.thr_assert), .full_in(lnk.full),
		.empty_in(lnk.empty), .rd_valid_in(lnk.rd_valid),
		.low_mark_in(lnk.low_mark), .data_count_in(lnk.data_count),
		.rd_count_in(lnk.rd_count));

	// 25 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; the slave's flops move by non-blocking
	// assignment, so right after an edge its outputs still show what
	// it presented at that edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		@(posedge clock_in);
		while (avs_waitrequest !== 1'b0 && n < 100) begin
			@(posedge clock_in);
			n++;
		end
		// A stuck slave counts against the run
		if (n == 100) begin
			chk(32'h1, 32'h0);
		end
		// Taken and released at the edge that saw waitrequest low
		rd_val = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Expected status word for k stored words and threshold t
	function automatic logic [31:0] stat(input int k, input int t);
		return 32'((k << 16) | (k << 8) | ((k <= t) << 2) |
			((k == 0) << 1) | (k == DEPTH_DEF - 1));
	endfunction

	// Push words and check the status after each
	task automatic fill(input int cnt, input int t);
		for (int k = 1; k <= cnt; k++) begin
			bus(1'b1, OFF_WDATA, 32'(k) + 32'hA0);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk(rd_val, stat(k, t));
		end
	endtask

	// Pop words in order and check data and status
	task automatic drain(input int cnt, input int t);
		for (int k = 1; k <= cnt; k++) begin
			bus(1'b0, OFF_RDATA, 32'h0);
			chk(rd_val, 32'(k) + 32'hA0);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk(rd_val, stat(cnt - k, t));
		end
	endtask

	task automatic t_reset();
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd_val, stat(0, THR_ASSERT_DEF));
		bus(1'b0, OFF_THRESH, 32'h0);
		chk(rd_val, 32'h0007_0004);
		bus(1'b0, 8'h20, 32'h0);
		chk(rd_val, 32'h0);
		$display("test reset done");
	endtask

	// Full depth both ways, full flag at the top
	task automatic t_full();
		fill(DEPTH_DEF - 1, THR_ASSERT_DEF);
		drain(DEPTH_DEF - 1, THR_ASSERT_DEF);
		$display("test full done");
	endtask

	// Threshold moves only while the FIFO is held in reset
	task automatic t_thresh();
		fill(3, THR_ASSERT_DEF);
		bus(1'b1, OFF_THRESH, 32'h000A_0002);
		bus(1'b0, OFF_THRESH, 32'h0);
		chk(rd_val, 32'h0007_0004);
		bus(1'b1, OFF_CTRL, 32'h1);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd_val, stat(0, THR_ASSERT_DEF));
		bus(1'b1, OFF_THRESH, 32'h000A_0008);
		bus(1'b1, OFF_CTRL, 32'h0);
		bus(1'b0, OFF_THRESH, 32'h0);
		chk(rd_val, 32'h000A_0008);
		fill(9, 8);
		drain(9, 8);
		$display("test threshold done");
	endtask

	// Reset in mid-run restores empty status and defaults
	task automatic t_rerun();
		fill(2, 8);
		@(posedge clock_in);
		resetn_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		t_reset();
		$display("test rerun done");
	endtask

	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		resetn_in = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		t_reset();
		t_full();
		t_thresh();
		t_rerun();
		test_done();
	end

	// Watchdog, well beyond the 119 transfers of the run
	initial begin
		#(40 * 20000);
		n_mismatch++;
		test_done();
	end
endmodule
`default_nettype wire
